// ### rtl/ptc_defs.svh
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the Wishbone slave.
// ----------------------------------------------------------------------------
`define PTC_OFS_CTRL0 8'h00
`define PTC_OFS_CTRL1 8'h04
`define PTC_OFS_CNT_LO 8'h08
`define PTC_OFS_CNT_HI 8'h0c
`define PTC_OFS_CMPA_LO 8'h10
`define PTC_OFS_CMPA_HI 8'h14
`define PTC_OFS_PER_LO 8'h18
`define PTC_OFS_PER_HI 8'h1c
`define PTC_OFS_STATUS 8'h20

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define PTC_C0_PAUSE 7
`define PTC_C0_CLKSEL_HI 6
`define PTC_C0_CLKSEL_LO 4
`define PTC_C0_ON 3
`define PTC_C1_MODE_HI 7
`define PTC_C1_MODE_LO 6
`define PTC_C1_PINFN_HI 5
`define PTC_C1_PINFN_LO 4
`define PTC_C1_INIT 3
`define PTC_C1_INV 2
`define PTC_C1_CAPSRC 1
`define PTC_C1_CLRSEL 0
`define PTC_ST_FLAGA 0
`define PTC_ST_FLAGP 1
`define PTC_ST_PIN 2

// ----------------------------------------------------------------------------
// Reset values and counter limits.
// ----------------------------------------------------------------------------
`define PTC_RST_BYTE 8'h00
`define PTC_RST_WORD 16'h0000
`define PTC_MAX_16 16'hffff
`define PTC_MAX_10 16'h03ff

// ----------------------------------------------------------------------------
// Prescaler terminal counts (divide by 4, 16 and 64).
// ----------------------------------------------------------------------------
`define PTC_DIV4_END 2'h3
`define PTC_DIV16_END 4'hf
`define PTC_DIV64_END 6'h3f

`endif

// ### rtl/ptc_pkg.sv
package ptc_pkg;

  // --------------------------------------------------------------------------
  // Operating modes.
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PTC_MODE_CMP = 2'b00,
    PTC_MODE_CAP = 2'b01,
    PTC_MODE_PWM = 2'b10,
    PTC_MODE_TMR = 2'b11
  } ptc_mode_t;

  // --------------------------------------------------------------------------
  // Whole state of the timer top, apart from the pin synchronisers.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic pause;
    logic [2:0] clkSel;
    logic on;
    ptc_mode_t mode;
    logic [1:0] pinFunc;
    logic outInit;
    logic outInv;
    logic capSrc;
    logic clrSel;
    logic [15:0] cmpA;
    logic [15:0] period;
    logic [15:0] count;
    logic onPrev;
    logic outLvl;
    logic pinOut;
    logic pinOeN;
    logic flagA;
    logic flagP;
    logic [5:0] div;
    logic ack;
    logic [7:0] rdData;
  } ptc_state_t;

  // --------------------------------------------------------------------------
  // State of one pin synchroniser.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] shift;
  } ptc_sync_t;

endpackage : ptc_pkg

// ### rtl/ptc_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none

module ptc_edge_sync
  import ptc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Raw pin and its edges.
  input wire logic pinIn,
  output logic rise,
  output logic fall
);

  // Two synchroniser stages plus one history stage.
  ptc_sync_t s_r;
  ptc_sync_t s_nxt;

  // --------------------------------------------------------------------------
  // Shift the pin in; stage 0 feeds only stage 1.
  // --------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.shift = {s_r.shift[1:0], pinIn};
  end

  // Edges are seen only between the settled stages, never on the first one.
  assign rise = s_r.shift[1] & ~s_r.shift[2];
  assign fall = ~s_r.shift[1] & s_r.shift[2];

  // Register the state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : ptc_edge_sync

`default_nettype wire

// ### rtl/ptc_timer.sv
// Notes on behaviour
// - Pause holds count; clearing resumes from it.
// - Three-bit field selects the counter clock.
// - Timer on rising edge zeroes and starts counter.
// - Timer on falling edge stops, keeps count.
// - Compare mode: on rising restores initial level.
// - Two-bit field selects operating mode.
// - Timer/counter mode leaves output pin undriven.
// - Compare mode: match A holds/low/high/toggles pin.
// - PWM mode: inactive, active, PWM, single pulse.
// - Capture mode: rise, fall, both or none.
// - No pin change when level equals initial.
// - Initial level, or PWM active polarity.
// - Invert bit flips the driven output.
// - Capture source: capture pin or clock pin.
// - Clear on match A, or on P/overflow.
// - Overflow clears only when period is zero.
// - Clear select ignored in PWM and capture.
// - 10-bit variant: high bytes keep two bits.
// - 16-bit variant: full period high byte.
// - 16-bit variant: full compare A high byte.
// - Count-up counter with two comparators.
// - Only match A moves the pin; flags raised.
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ptc_defs.svh"

module ptc_timer
  import ptc_pkg::*;
#(
  // One selects the 16-bit variant, zero the 10-bit variant.
  parameter bit WIDE16 = 1'b1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Classic Wishbone slave, 8-bit registers in the low byte lane.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  // Slow clock tick, one cycle wide.
  input wire logic subClockTick,
  // Pins.
  input wire logic extClockPin,
  input wire logic captureInputPin,
  output logic timerOutputPinO,
  output logic timerOutputPinOeN,
  // Event flags for the surrounding logic.
  output logic matchAFlag,
  output logic matchPFlag
);

  // --------------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------------
  ptc_state_t s_r; // Registered state.
  ptc_state_t s_nxt; // Next state.
  logic [1:0] pinRise; // Synchronised rising edges, bit 1 is the clock pin.
  logic [1:0] pinFall; // Synchronised falling edges.
  logic [1:0] rawPins; // Pins in the order of the edge vectors.
  logic [15:0] cntMax; // Last count before wrap.
  logic onRise; // Timer switched on this cycle.
  logic srcTick; // Selected clock source fires.
  logic tick; // Counter advances this cycle.
  logic matchA; // Comparator A match on a tick.
  logic matchP; // Comparator P match on a tick.
  logic perZero; // Period value is zero.
  logic ovf; // Counter at its top on a tick.
  logic clrCnt; // Counter clears instead of incrementing.
  logic singlePulse; // Single-pulse output selected.
  logic capRise; // Rising edge on the capture source.
  logic capFall; // Falling edge on the capture source.
  logic capEvent; // Capture trigger taken.
  logic pwmActive; // PWM waveform in its active phase.
  logic setA; // Hardware sets flag A.
  logic setP; // Hardware sets flag P.
  logic reqValid; // Fresh bus request this cycle.
  logic wrEn; // Register write strobe.
  logic [7:0] wrByte; // Written byte.
  logic [7:0] hiMask; // Implemented bits of a high byte.
  logic [7:0] nextLvlCmp; // Scratch for the compare-mode level.

  assign rawPins = {extClockPin, captureInputPin};

  // --------------------------------------------------------------------------
  // Pin synchronisers, one per input pin.
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gSync
      // Both pins are resynchronised before the counter or capture sees them.
      ptc_edge_sync uSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn(rawPins[gi]),
        .rise(pinRise[gi]),
        .fall(pinFall[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Next-state logic: counter, comparators, output pin and bus slave.
  // --------------------------------------------------------------------------
  always_comb begin
    nextLvlCmp = 8'h00;
    s_nxt = s_r;
    // Counter width follows the variant.
    cntMax = WIDE16 ? `PTC_MAX_16 : `PTC_MAX_10;
    hiMask = WIDE16 ? 8'hff : 8'h03;
    onRise = s_r.on & ~s_r.onPrev;
    s_nxt.onPrev = s_r.on;
    // Free-running prescaler shared by the divided sources.
    s_nxt.div = s_r.div + 6'h01;
    // Source selection.
    unique case (s_r.clkSel)
      3'b000: srcTick = (s_r.div[1:0] == `PTC_DIV4_END);
      3'b001: srcTick = 1'b1;
      3'b010: srcTick = (s_r.div[3:0] == `PTC_DIV16_END);
      3'b011: srcTick = (s_r.div == `PTC_DIV64_END);
      3'b100, 3'b101: srcTick = subClockTick;
      3'b110: srcTick = pinRise[1];
      3'b111: srcTick = pinFall[1];
    endcase
    // Counting needs the timer on and not paused; the start edge only zeroes.
    tick = s_r.on & ~s_r.pause & ~onRise & srcTick;
    singlePulse = (s_r.mode == PTC_MODE_PWM) && (s_r.pinFunc == 2'b11);
    perZero = (s_r.period == `PTC_RST_WORD);
    matchA = tick & (s_r.count == s_r.cmpA);
    matchP = tick & ~perZero & (s_r.count == s_r.period);
    ovf = tick & (s_r.count == cntMax);
    // Clear condition per mode.
    unique case (s_r.mode)
      PTC_MODE_CMP, PTC_MODE_TMR: begin
        if (s_r.clrSel) begin
          clrCnt = matchA;
        end else begin
          clrCnt = matchP | (perZero & ovf);
        end
      end
      default: begin
        // Capture and PWM clear on the period comparator, or on overflow with a zero period; single pulse not at all.
        clrCnt = singlePulse ? 1'b0 : (matchP | (perZero & ovf));
      end
    endcase
    // Counter update; a zeroed period lets it run through its full range.
    if (onRise) begin
      s_nxt.count = `PTC_RST_WORD;
    end else if (tick) begin
      s_nxt.count = clrCnt ? `PTC_RST_WORD : ((s_r.count + 16'h0001) & cntMax);
    end
    // Capture trigger from the chosen source pin.
    capRise = s_r.capSrc ? pinRise[1] : pinRise[0];
    capFall = s_r.capSrc ? pinFall[1] : pinFall[0];
    unique case (s_r.pinFunc)
      2'b00: capEvent = capRise;
      2'b01: capEvent = capFall;
      2'b10: capEvent = capRise | capFall;
      2'b11: capEvent = 1'b0;
    endcase
    capEvent = capEvent & s_r.on & (s_r.mode == PTC_MODE_CAP);
    if (capEvent) begin
      s_nxt.cmpA = s_r.count;
    end
    // Flags: match A except in capture, where a capture raises it instead.
    setA = (s_r.mode == PTC_MODE_CAP) ? capEvent : matchA;
    setP = matchP & ~singlePulse;
    if ((s_r.mode == PTC_MODE_CMP) || (s_r.mode == PTC_MODE_TMR)) begin
      setP = matchP & ~s_r.clrSel;
    end
    // PWM phase; a duty at or above a nonzero period gives full duty.
    pwmActive = (s_r.count < s_r.cmpA) | (~perZero & (s_r.cmpA >= s_r.period));
    // Output level before the invert stage.
    unique case (s_r.mode)
      PTC_MODE_CMP: begin
        if (onRise) begin
          s_nxt.outLvl = s_r.outInit;
        end else if (matchA) begin
          // Forcing to the present level leaves the pin as it stands.
          unique case (s_r.pinFunc)
            2'b00: nextLvlCmp[0] = s_r.outLvl;
            2'b01: nextLvlCmp[0] = 1'b0;
            2'b10: nextLvlCmp[0] = 1'b1;
            2'b11: nextLvlCmp[0] = ~s_r.outLvl;
          endcase
          s_nxt.outLvl = nextLvlCmp[0];
        end
      end
      PTC_MODE_PWM: begin
        // Initial-level bit picks the active polarity here.
        unique case (s_r.pinFunc)
          2'b00: s_nxt.outLvl = ~s_r.outInit;
          2'b01: s_nxt.outLvl = s_r.outInit;
          2'b10: s_nxt.outLvl = (s_r.on & pwmActive) ? s_r.outInit : ~s_r.outInit;
          2'b11: s_nxt.outLvl = s_r.on ? s_r.outInit : ~s_r.outInit;
        endcase
      end
      default: begin
        s_nxt.outLvl = s_r.outLvl;
      end
    endcase
    // Pin is released in timer/counter and capture modes.
    s_nxt.pinOeN = (s_r.mode == PTC_MODE_TMR) || (s_r.mode == PTC_MODE_CAP);
    s_nxt.pinOut = s_nxt.pinOeN ? 1'b0 : (s_nxt.outLvl ^ s_r.outInv);
    // Single pulse: clock pin edge starts it, match A ends it.
    if (singlePulse && pinRise[1]) begin
      s_nxt.on = 1'b1;
    end
    if (singlePulse && matchA) begin
      s_nxt.on = 1'b0;
    end

    // ------------------------------------------------------------------------
    // Wishbone slave: one wait state, ack drops after one cycle.
    // ------------------------------------------------------------------------
    reqValid = cyc_i & stb_i & ~s_r.ack;
    s_nxt.ack = reqValid;
    wrEn = reqValid & we_i & sel_i[0];
    wrByte = dat_i[7:0];
    // Flag clears come first so that a same-cycle event survives.
    if (wrEn && (adr_i == `PTC_OFS_STATUS)) begin
      if (wrByte[`PTC_ST_FLAGA]) begin
        s_nxt.flagA = 1'b0;
      end
      if (wrByte[`PTC_ST_FLAGP]) begin
        s_nxt.flagP = 1'b0;
      end
    end
    if (setA) begin
      s_nxt.flagA = 1'b1;
    end
    if (setP) begin
      s_nxt.flagP = 1'b1;
    end
    // Software writes land after hardware updates and so win over them.
    if (wrEn) begin
      unique case (adr_i)
        `PTC_OFS_CTRL0: begin
          s_nxt.pause = wrByte[`PTC_C0_PAUSE];
          s_nxt.clkSel = wrByte[`PTC_C0_CLKSEL_HI:`PTC_C0_CLKSEL_LO];
          s_nxt.on = wrByte[`PTC_C0_ON];
        end
        `PTC_OFS_CTRL1: begin
          s_nxt.mode = ptc_mode_t'(wrByte[`PTC_C1_MODE_HI:`PTC_C1_MODE_LO]);
          s_nxt.pinFunc = wrByte[`PTC_C1_PINFN_HI:`PTC_C1_PINFN_LO];
          s_nxt.outInit = wrByte[`PTC_C1_INIT];
          s_nxt.outInv = wrByte[`PTC_C1_INV];
          s_nxt.capSrc = wrByte[`PTC_C1_CAPSRC];
          s_nxt.clrSel = wrByte[`PTC_C1_CLRSEL];
        end
        `PTC_OFS_CMPA_LO: s_nxt.cmpA[7:0] = wrByte;
        `PTC_OFS_CMPA_HI: s_nxt.cmpA[15:8] = wrByte & hiMask;
        `PTC_OFS_PER_LO: s_nxt.period[7:0] = wrByte;
        `PTC_OFS_PER_HI: s_nxt.period[15:8] = wrByte & hiMask;
        default: begin
          // Read-only and unmapped offsets ignore writes.
        end
      endcase
    end
    // Read mux; unused bits and unmapped offsets read as zero.
    unique case (adr_i)
      `PTC_OFS_CTRL0: s_nxt.rdData = {s_r.pause, s_r.clkSel, s_r.on, 3'h0};
      `PTC_OFS_CTRL1: s_nxt.rdData = {s_r.mode, s_r.pinFunc, s_r.outInit, s_r.outInv, s_r.capSrc, s_r.clrSel};
      `PTC_OFS_CNT_LO: s_nxt.rdData = s_r.count[7:0];
      `PTC_OFS_CNT_HI: s_nxt.rdData = s_r.count[15:8] & hiMask;
      `PTC_OFS_CMPA_LO: s_nxt.rdData = s_r.cmpA[7:0];
      `PTC_OFS_CMPA_HI: s_nxt.rdData = s_r.cmpA[15:8] & hiMask;
      `PTC_OFS_PER_LO: s_nxt.rdData = s_r.period[7:0];
      `PTC_OFS_PER_HI: s_nxt.rdData = s_r.period[15:8] & hiMask;
      `PTC_OFS_STATUS: s_nxt.rdData = {5'h00, s_r.pinOut, s_r.flagP, s_r.flagA};
      default: s_nxt.rdData = `PTC_RST_BYTE;
    endcase
    if (!reqValid) begin
      s_nxt.rdData = `PTC_RST_BYTE;
    end
  end

  // --------------------------------------------------------------------------
  // Register the state; after reset compare mode drives the pin low.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------------
  assign ack_o = s_r.ack;
  assign dat_o = {24'h000000, s_r.rdData};
  assign timerOutputPinO = s_r.pinOut;
  assign timerOutputPinOeN = s_r.pinOeN;
  assign matchAFlag = s_r.flagA;
  assign matchPFlag = s_r.flagP;

endmodule : ptc_timer

`default_nettype wire

// ### verification/ptc_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "ptc_defs.svh"
// ------
// Port checker of the timer.
// ------
module ptc_timer_chk
  import ptc_pkg::*;
#(
  parameter bit WIDE16 = 1'b1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Bus.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // Pins and flags.
  input wire logic subClockTick,
  input wire logic extClockPin,
  input wire logic captureInputPin,
  input wire logic timerOutputPinO,
  input wire logic timerOutputPinOeN,
  input wire logic matchAFlag,
  input wire logic matchPFlag
);
  // A request is taken on an edge where it stands unanswered.
  logic take;
  logic wrSt;
  logic [1:0] modeR;
  logic [1:0] ageR;
  assign take = cyc_i && stb_i && !ack_o;
  assign wrSt = take && we_i && sel_i[0] && adr_i == `PTC_OFS_STATUS;
  // Mode last written and its age; the pin is judged only once the write has settled.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      modeR <= 2'h0;
      ageR <= 2'h0;
    end else if (take && we_i && sel_i[0] && adr_i == `PTC_OFS_CTRL1) begin
      modeR <= dat_i[7:6];
      ageR <= 2'h0;
    end else if (ageR != 2'h3) begin
      ageR <= ageR + 2'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (take |=> ack_o)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property (ack_o |-> $past(take))
    else $error("ack without request");
  dat_upper_a: assert property (dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  reset_pin_a: assert property ($fell(rst) |-> !timerOutputPinO && !timerOutputPinOeN)
    else $error("pin not low and driven after reset");
  pin_release_a: assert property (ageR == 2'h3 && modeR[0] |-> timerOutputPinOeN && !timerOutputPinO)
    else $error("pin driven in input or counter mode");
  pin_drive_a: assert property (ageR == 2'h3 && !modeR[0] |-> !timerOutputPinOeN)
    else $error("pin not driven in output mode");
  flaga_clear_a: assert property ($fell(matchAFlag) && !$past(rst) |-> $past(wrSt && dat_i[0]))
    else $error("flag A cleared without write");
  flagp_clear_a: assert property ($fell(matchPFlag) && !$past(rst) |-> $past(wrSt && dat_i[1]))
    else $error("flag P cleared without write");
  match_a_c: cover property ($rose(matchAFlag));
  match_p_c: cover property ($rose(matchPFlag));
  release_c: cover property ($rose(timerOutputPinOeN));
endmodule : ptc_timer_chk
bind ptc_timer ptc_timer_chk #(.WIDE16(WIDE16)) ptc_timer_chk_inst (.clk_sys(clk_sys), .rst(rst),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o),
  .dat_o(dat_o), .subClockTick(subClockTick), .extClockPin(extClockPin), .captureInputPin(captureInputPin),
  .timerOutputPinO(timerOutputPinO), .timerOutputPinOeN(timerOutputPinOeN), .matchAFlag(matchAFlag),
  .matchPFlag(matchPFlag));
`default_nettype wire

// ### verification/ptc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// Far side: clock and capture drivers, pulled-up output wire.
// ------
module ptc_pin_model (
  // Clock.
  input wire logic clk_sys,
  // Output pin of the timer.
  input wire logic pinO,
  input wire logic pinOeN,
  // Pins driven here and the wire level.
  output logic extClockPin,
  output logic captureInputPin,
  output logic pinLevel
);
  // A released pin floats up to the pull-up level.
  assign pinLevel = pinOeN ? 1'b1 : pinO;
  initial begin
    extClockPin = 1'b0;
    captureInputPin = 1'b0;
  end
  // Pulses on one pin; each level lasts at least w cycles so the synchroniser sees every edge.
  task automatic pulses(input logic onExt, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      extClockPin <= onExt;
      captureInputPin <= !onExt;
      repeat (w) @(posedge clk_sys);
      extClockPin <= 1'b0;
      captureInputPin <= 1'b0;
      repeat (w) @(posedge clk_sys);
    end
  endtask : pulses
endmodule : ptc_pin_model
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ptc_pkg::*;
  // ------
  // Stimulus and observed signals.
  // ------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] datW = 32'h0;
  logic [3:0] sel = 4'h0;
  logic subTick = 1'b0;
  logic ack, pinO, pinOeN, flagA, flagP, ext, cap, pinLevel;
  logic [31:0] datR;
  int mismatches = 0;
  int samplesChecked = 0;
  int seed;
  always #5 clk_sys = ~clk_sys;
  ptc_timer #(.WIDE16(1'b1)) ptc_timer_inst (.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(datW), .sel_i(sel), .ack_o(ack), .dat_o(datR), .subClockTick(subTick),
    .extClockPin(ext), .captureInputPin(cap), .timerOutputPinO(pinO), .timerOutputPinOeN(pinOeN),
    .matchAFlag(flagA), .matchPFlag(flagP));
  ptc_pin_model ptc_pin_model_inst (.clk_sys(clk_sys), .pinO(pinO), .pinOeN(pinOeN), .extClockPin(ext),
    .captureInputPin(cap), .pinLevel(pinLevel));
  // ------
  // Bus cycles, comparisons and expectations.
  // ------
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= {24'h0, d};
    sel <= 4'h1;
    @(posedge clk_sys);
    // Wait for the answer; only the watchdog ends a stuck wait.
    while (ack !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = datR[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    wb(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    samplesChecked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  function automatic logic [7:0] c1(input logic [1:0] m, input logic [1:0] pf, input logic i, v, cs, cl);
    return {m, pf, i, v, cs, cl};
  endfunction : c1
  // Pin level after a match A in compare mode.
  function automatic logic pinExp(input logic [1:0] pf, input logic ini);
    return pf == 2'h0 ? ini : pf == 2'h1 ? 1'b0 : pf == 2'h2 ? 1'b1 : !ini;
  endfunction : pinExp
  // Counter runs from sysclk in counter mode; checks its bound and the flags.
  task automatic clrRun(input logic [7:0] per, input logic [7:0] cmp, input logic cl);
    logic [7:0] a;
    wr(8'h00, 8'h00);
    wr(8'h18, per);
    wr(8'h10, cmp);
    wr(8'h04, c1(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, cl));
    wr(8'h20, 8'h03);
    wr(8'h00, 8'h18);
    for (int i = 0; i < 6; i++) begin
      repeat ($random(seed) & 15) @(posedge clk_sys);
      rd(8'h08, a);
      chk1("countMax", 1'b1, a <= (cl ? cmp : per));
    end
    chk1("flagP", !cl, flagP);
    chk1("flagA", cl, flagA);
  endtask : clrRun
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
  // ------
  // Main sequence.
  // ------
  initial begin
    logic [7:0] ra[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h3c};
    logic [2:0] src[4] = '{3'h6, 3'h7, 3'h4, 3'h5};
    logic [7:0] a, b, d;
    logic [1:0] pf;
    logic ini, inv;
    int n;
    seed = 32'h7db75339;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(ra[i], a);
      chk8("resetValue", 8'h00, a);
    end
    // Random write and read back; the counter is read only and the timer stays off.
    for (int i = 0; i < 10; i++) begin
      d = 8'($random(seed)) & (i == 0 ? 8'hf7 : 8'hff);
      if (i == 8) continue;
      wr(ra[i], d);
      rd(ra[i], a);
      chk8("regValue", (i == 2 || i == 3 || i == 9) ? 8'h00 : (i == 0 ? d & 8'hf0 : d), a);
    end
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h04);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'hc8);
    wr(8'h1c, 8'h00);
    // Compare mode over every pin function and initial level.
    for (int k = 0; k < 8; k++) begin
      pf = k[1:0];
      ini = k[2];
      inv = 1'($random(seed));
      wr(8'h00, 8'h00);
      wr(8'h04, c1(2'h0, pf, ini, inv, 1'b0, 1'b0));
      wr(8'h20, 8'h03);
      wr(8'h00, 8'h18);
      repeat (2) @(posedge clk_sys);
      chk1("pinInit", ini ^ inv, pinLevel);
      repeat (20) @(posedge clk_sys);
      chk1("pinMatch", pinExp(pf, ini) ^ inv, pinLevel);
      chk1("flagA", 1'b1, flagA);
      chk1("drive", 1'b0, pinOeN);
    end
    // Pause, stop and restart in counter mode.
    wr(8'h00, 8'h00);
    wr(8'h04, c1(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h18);
    repeat (30) @(posedge clk_sys);
    wr(8'h00, 8'h98);
    rd(8'h08, a);
    repeat (20) @(posedge clk_sys);
    rd(8'h08, b);
    chk8("pause", a, b);
    wr(8'h00, 8'h18);
    repeat (10) @(posedge clk_sys);
    rd(8'h08, b);
    d = b - a;
    chk1("resume", 1'b1, d > 8'h05 && d < 8'h20);
    wr(8'h00, 8'h10);
    rd(8'h08, a);
    repeat (20) @(posedge clk_sys);
    rd(8'h08, b);
    chk8("stop", a, b);
    wr(8'h00, 8'h18);
    rd(8'h08, b);
    chk1("restart", 1'b1, b < 8'h08);
    chk1("release", 1'b1, pinLevel);
    clrRun(8'h0a, 8'h30, 1'b0);
    clrRun(8'h40, 8'h07, 1'b1);
    // Event clock sources count exactly the events given.
    wr(8'h18, 8'h00);
    for (int i = 0; i < 4; i++) begin
      n = 3 + ($random(seed) & 7);
      wr(8'h00, 8'h00);
      wr(8'h04, c1(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
      wr(8'h00, {1'b0, src[i], 4'h8});
      if (src[i][2:1] == 2'h3) ptc_pin_model_inst.pulses(1'b1, n, 4);
      else repeat (n) begin
        @(posedge clk_sys);
        subTick <= 1'b1;
        @(posedge clk_sys);
        subTick <= 1'b0;
        repeat (3) @(posedge clk_sys);
      end
      repeat (8) @(posedge clk_sys);
      rd(8'h08, a);
      chk8("events", n[7:0], a);
    end
    // Capture on each trigger setting from either pin.
    for (int k = 0; k < 4; k++) begin
      inv = 1'($random(seed));
      wr(8'h00, 8'h00);
      // Zero the capture register so that a missing capture shows.
      wr(8'h10, 8'h00);
      wr(8'h04, c1(2'h1, k[1:0], 1'b0, 1'b0, inv, 1'b0));
      wr(8'h20, 8'h03);
      wr(8'h00, 8'h18);
      ptc_pin_model_inst.pulses(inv, 1, 5);
      repeat (6) @(posedge clk_sys);
      chk1("capture", k != 3, flagA);
      rd(8'h10, a);
      chk1("capValue", k != 3, a != 8'h00);
      chk1("capRelease", 1'b1, pinOeN);
    end
    // PWM: forced inactive, forced active, then the duty over one period.
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h04);
    wr(8'h18, 8'h0a);
    for (int k = 0; k < 3; k++) begin
      ini = 1'($random(seed));
      wr(8'h04, c1(2'h2, k[1:0], ini, 1'b0, 1'b0, 1'b0));
      wr(8'h00, 8'h18);
      repeat (4) @(posedge clk_sys);
      n = 0;
      // The count runs 0 to the period, so one period is eleven cycles.
      repeat (11) begin
        @(posedge clk_sys);
        n += (pinLevel === ini);
      end
      chk8("pwmActive", k == 0 ? 8'h00 : (k == 1 ? 8'h0b : 8'h04), n[7:0]);
      wr(8'h00, 8'h00);
    end
    summarize();
  end
endmodule : tb
`default_nettype wire
